// file: core/lvd_ctrl.sv
// Purpose: digital control of a low-voltage detector with APB registers
// Assumes: comparator output is asynchronous; sys_rst_req is a same-clock reset from other sources
// Notes: presetn is power-on reset and clears everything; detector reset keeps control bits
`timescale 1ns/1ps
`include "lvd_defines.svh"
module lvd_ctrl #(
  parameter int LEVEL_W = `LVD_LEVEL_W,
  parameter int LEVELS = `LVD_LEVELS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`LVD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system reset from other sources
  input wire logic sys_rst_req,
  // analog comparator
  input wire logic cmp_below,
  output lvd_pkg::lvd_ana_s ana_req,
  // reset and interrupts
  output logic detector_reset,
  output logic low_voltage_irq,
  output logic irq
);
  // the register map has room for one four-bit level code only
  if (LEVEL_W != `LVD_LEVEL_W || LEVELS != (1 << LEVEL_W)) begin : g_bad_params
    $error("lvd_ctrl: LEVELS must be 2**LEVEL_W and LEVEL_W must match the register");
  end : g_bad_params

  logic below_s;
  lvd_pkg::lvd_ctrl_s ctrl_r;
  lvd_pkg::lvd_ctrl_s ctrl_nxt;
  logic [LEVEL_W-1:0] level_r;
  logic [LEVEL_W-1:0] level_nxt;
  logic cause_r;
  logic cause_nxt;
  logic [`LVD_EV_W-1:0] stat_r;
  logic [`LVD_EV_W-1:0] stat_nxt;
  logic [`LVD_EV_W-1:0] mask_r;
  logic [`LVD_EV_W-1:0] mask_nxt;
  logic flag_prev_r;
  logic flag_prev_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic below_flag;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic [`LVD_EV_W-1:0] ev_set;

  // comparator result crosses into pclk before any use
  lvd_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(cmp_below),
    .sync_out(below_s)
  );

  assign mapped = (paddr == `LVD_OFS_CTRL) || (paddr == `LVD_OFS_LEVEL) || (paddr == `LVD_OFS_CAUSE) ||
                  (paddr == `LVD_OFS_STAT) || (paddr == `LVD_OFS_MASK);
  // read data is captured in the setup cycle so the access phase never waits
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;

  assign below_flag = ctrl_r.on && below_s;
  assign detector_reset = ctrl_r.on && ctrl_r.mode && below_s;
  assign low_voltage_irq = below_flag && ctrl_r.on && !ctrl_r.mode;
  assign irq = |(stat_r & mask_r);

  // both crossings are events in interrupt mode
  always_comb begin
    ev_set = '0;
    if (ctrl_r.on && !ctrl_r.mode) begin
      ev_set[`LVD_EV_FALL] = below_flag && !flag_prev_r;
      ev_set[`LVD_EV_RISE] = !below_flag && flag_prev_r;
    end
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    level_nxt = level_r;
    cause_nxt = cause_r;
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    flag_prev_nxt = below_flag;
    rdata_nxt = rdata_r;
    if (wr_en) begin
      case (paddr)
        `LVD_OFS_CTRL: begin
          ctrl_nxt.on = pwdata[`LVD_BIT_ON];
          ctrl_nxt.src = pwdata[`LVD_BIT_SRC];
          ctrl_nxt.mode = pwdata[`LVD_BIT_MODE];
        end
        // a change while running is a software fault; the code is still taken
        `LVD_OFS_LEVEL: level_nxt = pwdata[LEVEL_W-1:0];
        `LVD_OFS_CAUSE: cause_nxt = cause_r & ~pwdata[`LVD_BIT_CAUSE];
        `LVD_OFS_STAT: stat_nxt = stat_r & ~pwdata[`LVD_EV_W-1:0];
        `LVD_OFS_MASK: mask_nxt = pwdata[`LVD_EV_W-1:0];
        default: ;
      endcase
    end
    // hardware sets win over a same-cycle software clear
    stat_nxt = stat_nxt | ev_set;
    if (detector_reset) begin
      cause_nxt = 1'b1;
      // the detector reset clears the level select but not the control bits
      level_nxt = `LVD_LEVEL_RST;
    end
    if (sys_rst_req) begin
      ctrl_nxt = '0;
      level_nxt = `LVD_LEVEL_RST;
      stat_nxt = `LVD_EV_RST;
      mask_nxt = `LVD_EV_RST;
    end
    if (rd_setup) begin
      rdata_nxt = '0;
      case (paddr)
        `LVD_OFS_CTRL: begin
          rdata_nxt[`LVD_BIT_ON] = ctrl_r.on;
          rdata_nxt[`LVD_BIT_SRC] = ctrl_r.src;
          rdata_nxt[`LVD_BIT_MODE] = ctrl_r.mode;
          rdata_nxt[`LVD_BIT_FLAG] = below_flag;
        end
        `LVD_OFS_LEVEL: rdata_nxt[LEVEL_W-1:0] = level_r;
        `LVD_OFS_CAUSE: rdata_nxt[`LVD_BIT_CAUSE] = cause_r;
        `LVD_OFS_STAT: rdata_nxt[`LVD_EV_W-1:0] = stat_r;
        `LVD_OFS_MASK: rdata_nxt[`LVD_EV_W-1:0] = mask_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '0;
      level_r <= `LVD_LEVEL_RST;
      cause_r <= 1'b0;
      stat_r <= `LVD_EV_RST;
      mask_r <= `LVD_EV_RST;
      flag_prev_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      level_r <= level_nxt;
      cause_r <= cause_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      flag_prev_r <= flag_prev_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign prdata = rdata_r;
  // one driver for the whole struct keeps the port a single variable
  assign ana_req = '{enable: ctrl_r.on, src: ctrl_r.src, level: level_r};

  // checks
  sequence s_below_steady;
    $rose(cmp_below) ##1 cmp_below [*5];
  endsequence

  sequence s_ctrl_write;
    wr_en && (paddr == `LVD_OFS_CTRL) && !sys_rst_req;
  endsequence

  a_flag_when_off: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_r.on |-> !below_flag && !detector_reset && !low_voltage_irq)
    else $error("flag or request active while detector off");

  a_sync_to_flag: assert property (@(posedge pclk) disable iff (!presetn)
    s_below_steady ##0 (ctrl_r.on && $stable(ctrl_r.on)) |-> below_flag)
    else $error("steady below level not seen as flag");

  a_reset_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r.on && ctrl_r.mode && below_s) |-> detector_reset ##1 (detector_reset || !below_s || !ctrl_r.on || !ctrl_r.mode))
    else $error("detector reset not held while below");

  a_cause_set: assert property (@(posedge pclk) disable iff (!presetn)
    detector_reset && !sys_rst_req |=> cause_r)
    else $error("detector reset did not set cause flag");

  a_fall_event: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r.on && !ctrl_r.mode && below_flag && !flag_prev_r && !sys_rst_req) |=> stat_r[`LVD_EV_FALL])
    else $error("falling crossing not recorded");

  a_rise_event: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r.on && !ctrl_r.mode && !below_flag && flag_prev_r && !sys_rst_req) |=> stat_r[`LVD_EV_RISE])
    else $error("rising crossing not recorded");

  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    low_voltage_irq |-> (ctrl_r.on && !ctrl_r.mode && below_s))
    else $error("interrupt request outside interrupt mode");

  a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `LVD_OFS_CTRL && !sys_rst_req) |=>
      (ctrl_r.mode == $past(pwdata[`LVD_BIT_MODE]) && ctrl_r.src == $past(pwdata[`LVD_BIT_SRC])))
    else $error("control write not stored");

  a_ctrl_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (detector_reset && !sys_rst_req && !wr_en) |=> $stable(ctrl_r))
    else $error("detector reset disturbed control bits");

  a_ctrl_clear: assert property (@(posedge pclk) disable iff (!presetn)
    sys_rst_req |=> (ctrl_r == '0) && (level_r == '0))
    else $error("system reset did not clear control");

  // a single sample of the comparator never reaches the flag
  a_sync_filter: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(below_s) |-> (below_s == $past(cmp_below, 3)) && (below_s == $past(cmp_below, 4)))
    else $error("synchronised level moved without two agreeing stages");

  a_reset_release: assert property (@(posedge pclk) disable iff (!presetn)
    !below_s |-> !detector_reset)
    else $error("detector reset held at or above threshold");

  a_on_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl_write |=> (ctrl_r.on == $past(pwdata[`LVD_BIT_ON])))
    else $error("detector on bit not stored");

  a_src_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl_write |=> (ana_req.src == $past(pwdata[`LVD_BIT_SRC])))
    else $error("source select not passed to comparator");

  a_level_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && (paddr == `LVD_OFS_LEVEL) && !detector_reset && !sys_rst_req) |=>
      (ana_req.level == $past(pwdata[LEVEL_W-1:0])))
    else $error("level code not passed to comparator");

  a_level_clear: assert property (@(posedge pclk) disable iff (!presetn)
    detector_reset |=> (level_r == `LVD_LEVEL_RST))
    else $error("detector reset kept the level code");

  a_flag_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && (paddr == `LVD_OFS_CTRL)) |=> (prdata[`LVD_BIT_FLAG] == $past(below_flag)))
    else $error("control read lost the below flag");

  a_off_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && (paddr == `LVD_OFS_CTRL) && !ctrl_r.on) |=> !prdata[`LVD_BIT_FLAG])
    else $error("below flag read as set while detector off");

  a_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r.on && !ctrl_r.mode && below_s) |-> low_voltage_irq)
    else $error("interrupt request missing while below in interrupt mode");

  a_cause_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (cause_r && !(wr_en && (paddr == `LVD_OFS_CAUSE) && pwdata[`LVD_BIT_CAUSE])) |=> cause_r)
    else $error("cause flag dropped without a clear");

  // each event bit is sticky until software writes a one to it or sys_rst_req clears it
  for (genvar e = 0; e < `LVD_EV_W; e++) begin : g_ev_chk
    a_stat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      (stat_r[e] && !sys_rst_req && !(wr_en && (paddr == `LVD_OFS_STAT) && pwdata[e])) |=> stat_r[e])
      else $error("status bit dropped without a clear");
  end : g_ev_chk

  a_no_event_off: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r.mode || !ctrl_r.on) |=> ((stat_r & ~$past(stat_r)) == '0))
    else $error("event recorded outside interrupt mode");

  a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
    ((stat_r & mask_r) != '0) |-> irq)
    else $error("unmasked event without interrupt");

  a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    ((stat_r & mask_r) == '0) |-> !irq)
    else $error("interrupt without unmasked event");

  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && (paddr == `LVD_OFS_MASK) && !sys_rst_req) |=> (mask_r == $past(pwdata[`LVD_EV_W-1:0])))
    else $error("mask write not stored");

  // writes to holes must not alias onto a real register
  a_hole_write: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && !mapped && !sys_rst_req && !detector_reset) |=>
      ($stable(ctrl_r) && $stable(level_r) && $stable(mask_r)))
    else $error("write to unmapped address changed a register");

  a_hole_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && !mapped) |=> (prdata == '0))
    else $error("unmapped read returned data");

  a_rdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_setup |=> $stable(prdata))
    else $error("read data moved outside a read setup");
endmodule : lvd_ctrl

// file: core/lvd_defines.svh
// Purpose: constants for the low-voltage detector control block
// Assumes: APB word offsets, 32-bit data, pclk at 50 MHz
// Notes: holds definitions only
`ifndef LVD_DEFINES_SVH
`define LVD_DEFINES_SVH

`define LVD_ADDR_W 8
`define LVD_OFS_CTRL 8'h00
`define LVD_OFS_LEVEL 8'h04
`define LVD_OFS_CAUSE 8'h08
`define LVD_OFS_STAT 8'h0c
`define LVD_OFS_MASK 8'h10

`define LVD_BIT_ON 7
`define LVD_BIT_SRC 2
`define LVD_BIT_MODE 1
`define LVD_BIT_FLAG 0
`define LVD_BIT_CAUSE 0
`define LVD_EV_FALL 0
`define LVD_EV_RISE 1
`define LVD_EV_W 2
`define LVD_LEVEL_W 4
`define LVD_LEVELS 16

`define LVD_LEVEL_RST 4'h0
`define LVD_EV_RST 2'h0

`endif

// file: core/lvd_pkg.sv
// Purpose: shared types of the low-voltage detector control block
// Assumes: lvd_defines.svh included first
// Notes: no constants here, those are macros
`include "lvd_defines.svh"
package lvd_pkg;
  // control bits that survive a detector-caused reset
  typedef struct packed {
    logic on;
    logic src;
    logic mode;
  } lvd_ctrl_s;

  // request towards the analog comparator
  typedef struct packed {
    logic enable;
    logic src;
    logic [`LVD_LEVEL_W-1:0] level;
  } lvd_ana_s;
endpackage : lvd_pkg

// file: core/lvd_sync.sv
// Purpose: three-stage synchroniser with agreement filter for an async level
// Assumes: single clock pclk, async active-low reset
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
module lvd_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // level
  input wire logic async_in,
  output logic sync_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic out_r;
  logic out_nxt;

  always_comb begin
    out_nxt = (s2_r == s3_r) ? s3_r : out_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;
endmodule : lvd_sync

// file: sim/testbench.sv
// Purpose: self-checking bench for lvd_ctrl over apb
// Assumes: zero-wait apb slave, comparator level seen after four edges
// Notes: reset-value reads first, then table loop, interrupt, reset-mode, sys reset and power-on reset cases
`timescale 1ns/1ps
`include "lvd_defines.svh"
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sys_rst_req = 1'b0;
  logic cmp_below = 1'b0;
  lvd_pkg::lvd_ana_s ana_req;
  logic detector_reset;
  logic low_voltage_irq;
  logic irq;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  // table: address, expected readback after writing 0xff, expected slave error
  // the level row runs before the detector is switched on
  logic [7:0] t_a [6] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h0c, 8'h00};
  logic [31:0] t_e [6] = '{32'h0f, 32'h00, 32'h03, 32'h00, 32'h00, 32'h86};
  logic t_r [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  always #10 pclk = ~pclk;
  lvd_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_rst_req(sys_rst_req), .cmp_below(cmp_below), .ana_req(ana_req),
    .detector_reset(detector_reset), .low_voltage_irq(low_voltage_irq), .irq(irq));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  // settle past the edge so sampled outputs carry that edge's updates
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt
  // bit 8 reset, 7 detector irq, 6 irq, 5:0 comparator request
  function automatic logic [31:0] outs();
    return {23'h0, detector_reset, low_voltage_irq, irq, ana_req};
  endfunction : outs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wt(1);
    chk(outs(), 32'h0);
    chk(32'(pready), 32'h1);
    for (int i = 0; i < 5; i++) rdchk(8'(i * 4), 32'h0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, t_a[i], 32'hff);
      apb(1'b0, t_a[i], 32'h0);
      chk(rd, t_e[i]);
      chk(32'(er), 32'(t_r[i]));
    end
    apb(1'b1, `LVD_OFS_MASK, 32'h0);
    apb(1'b1, `LVD_OFS_CTRL, 32'h0);
    apb(1'b1, `LVD_OFS_LEVEL, 32'h5);
    apb(1'b1, `LVD_OFS_CTRL, 32'h84);
    wt(1);
    chk(outs(), 32'h35);
    @(posedge pclk) cmp_below <= 1'b1;
    wt(6);
    chk(outs(), 32'hb5);
    rdchk(`LVD_OFS_CTRL, 32'h85);
    rdchk(`LVD_OFS_STAT, 32'h1);
    apb(1'b1, `LVD_OFS_MASK, 32'h1);
    wt(1);
    chk(outs(), 32'hf5);
    @(posedge pclk) cmp_below <= 1'b0;
    wt(6);
    chk(outs(), 32'h75);
    rdchk(`LVD_OFS_STAT, 32'h3);
    apb(1'b1, `LVD_OFS_STAT, 32'h3);
    wt(1);
    chk(outs(), 32'h35);
    @(posedge pclk) cmp_below <= 1'b1;
    wt(6);
    apb(1'b1, `LVD_OFS_CTRL, 32'h0);
    rdchk(`LVD_OFS_CTRL, 32'h0);
    apb(1'b1, `LVD_OFS_STAT, 32'h3);
    @(posedge pclk) cmp_below <= 1'b0;
    apb(1'b1, `LVD_OFS_LEVEL, 32'h9);
    apb(1'b1, `LVD_OFS_CTRL, 32'h82);
    wt(6);
    chk(outs(), 32'h29);
    @(posedge pclk) cmp_below <= 1'b1;
    wt(2);
    chk(outs(), 32'h29);
    wt(4);
    chk(outs(), 32'h120);
    rdchk(`LVD_OFS_CTRL, 32'h83);
    rdchk(`LVD_OFS_CAUSE, 32'h1);
    rdchk(`LVD_OFS_LEVEL, 32'h0);
    @(posedge pclk) cmp_below <= 1'b0;
    wt(6);
    chk(outs(), 32'h20);
    @(posedge pclk) sys_rst_req <= 1'b1;
    @(posedge pclk) sys_rst_req <= 1'b0;
    rdchk(`LVD_OFS_CTRL, 32'h0);
    rdchk(`LVD_OFS_CAUSE, 32'h1);
    apb(1'b1, `LVD_OFS_CAUSE, 32'h1);
    rdchk(`LVD_OFS_CAUSE, 32'h0);
    // power-on reset in mid-run clears the bits a detector reset keeps
    apb(1'b1, `LVD_OFS_CTRL, 32'h86);
    rdchk(`LVD_OFS_CTRL, 32'h86);
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wt(1);
    chk(outs(), 32'h0);
    chk(prdata, 32'h0);
    rdchk(`LVD_OFS_CTRL, 32'h0);
    summarize();
  end
endmodule : testbench
